// File: verilog/autoneg_next_page_regs.sv
// Per-port next page transmit, partner next page and port configuration registers.
// Assumes a management front end that gives one-cycle read/write strobes on clock_i,
// and a negotiation engine on the same clock that delivers received pages as pulses.
// Contract
// - Transmit bit 15 more pages, reset 0
// - Reserved bits write zero, read zero
// - Transmit bit 13 message page, reset 1
// - Transmit bit 12 comply ack, reset 0
// - Transmit bit 11 toggle, reset 0
// - Transmit code field eleven bits, reset 1
// - Partner bit 15 more pages, reset 0
// - Partner bit 14 receipt ack, reset 0
// - Partner bit 13 message page, reset 0
// - Partner bit 12 comply ack, reset 0
// - Partner toggle and code field, reset 0
// - Latched status clears on read
// - Config bit 14 forces link pass
// - Config bit 13 disables transmitter
// - Config bit 0 loaded from pin
// - New page loads partner, sets flag
// - Alternate mode clears flag early
`timescale 1ns/10ps
`include "np_regs_map.svh"
module autoneg_next_page_regs
   import np_regs_pkg::*;
#(
   parameter int DATA_WIDTH = 16
) (
   input  wire logic         clock_i,
   input  wire logic         reset_i,
   input  wire logic         enable_i,
   input  wire mgmt_req_type mgmt_i,
   output logic [15:0]       read_data_o,
   output logic              read_valid_o,
   input  wire page_type     rx_page_i,
   input  wire logic         page_rx_active_i,
   input  wire logic         fiber_pin_i,
   output logic [15:0]       tx_page_o,
   output logic              link_pass_force_o,
   output logic              tx_disable_o,
   output logic              alt_np_enable_o,
   output logic              fiber_select_o,
   output logic              page_received_o
);

   initial begin
      if (DATA_WIDTH != 16) begin
         $error("Register width must be 16");
      end
   end

   logic [15:0] next_page_transmit;
   logic [15:0] partner_next_page;
   logic [15:0] port_configuration;
   logic        page_received;
   logic        fiber_meta;
   logic        fiber_sync;
   logic        strap_pending;

   wire hit_npt  = mgmt_i.addr == `NPT_OFFSET;
   wire hit_pnp  = mgmt_i.addr == `PNP_OFFSET;
   wire hit_pcfg = mgmt_i.addr == `PCFG_OFFSET;
   wire hit_pgrx = mgmt_i.addr == `PGRX_OFFSET;
   wire wr_npt   = enable_i && mgmt_i.write && hit_npt;
   wire wr_pcfg  = enable_i && mgmt_i.write && hit_pcfg;
   wire rd_pgrx  = enable_i && mgmt_i.read && hit_pgrx;
   wire new_page = enable_i && rx_page_i.valid;
   wire alt_clear = port_configuration[`BIT_ALT_NP]
                    && (!page_rx_active_i || port_configuration[`BIT_TX_DISABLE]);

   wire [15:0] npt_view  = next_page_transmit & `NPT_WRITE_MASK;
   wire [15:0] pcfg_view = port_configuration & `PCFG_WRITE_MASK;
   wire [15:0] pgrx_view = 16'(page_received) << `BIT_PAGE_RX;
   wire [15:0] read_mux  = hit_npt  ? npt_view :
                           hit_pnp  ? partner_next_page :
                           hit_pcfg ? pcfg_view :
                           hit_pgrx ? pgrx_view : 16'h0000;

   // Strap pin crosses in from outside; two flops before use
   always_ff @(posedge clock_i) begin
      fiber_meta <= fiber_pin_i;
      fiber_sync <= fiber_meta;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         next_page_transmit <= `NPT_RESET;
      end else if (wr_npt) begin
         next_page_transmit <= mgmt_i.wdata & `NPT_WRITE_MASK;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         partner_next_page <= `PNP_RESET;
      end else if (new_page) begin
         partner_next_page <= rx_page_i.word;
      end
   end

   // port configuration register
   // Strap is sampled one cycle after reset release so the async pin is synced
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         port_configuration <= `PCFG_RESET;
         strap_pending      <= 1'b1;
      end else if (enable_i) begin
         strap_pending <= 1'b0;
         if (wr_pcfg) begin
            port_configuration <= mgmt_i.wdata & `PCFG_WRITE_MASK;
         end else if (strap_pending) begin
            port_configuration[`BIT_FIBER] <= fiber_sync;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         page_received <= 1'b0;
      end else if (new_page) begin
         page_received <= 1'b1;
      end else if (enable_i && (rd_pgrx || alt_clear)) begin
         page_received <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         read_data_o  <= 16'h0000;
         read_valid_o <= 1'b0;
      end else if (enable_i) begin
         read_valid_o <= mgmt_i.read;
         if (mgmt_i.read) begin
            read_data_o <= read_mux;
         end
      end
   end

   assign tx_page_o         = npt_view;
   assign link_pass_force_o = port_configuration[`BIT_LINK_FORCE];
   assign tx_disable_o      = port_configuration[`BIT_TX_DISABLE];
   assign alt_np_enable_o   = port_configuration[`BIT_ALT_NP];
   assign fiber_select_o    = port_configuration[`BIT_FIBER];
   assign page_received_o   = page_received;

   // Transmit fields as the negotiation engine sees them
   wire        tx_more_pages   = tx_page_o[`BIT_MORE_PAGES];
   wire        tx_message_page = tx_page_o[`BIT_MESSAGE];
   wire        tx_comply       = tx_page_o[`BIT_COMPLY];
   wire        tx_toggle       = tx_page_o[`BIT_TOGGLE];
   wire [10:0] tx_code         = tx_page_o[`CODE_MSB:0];

   // Partner fields as management reads them
   wire        rx_more_pages   = partner_next_page[`BIT_MORE_PAGES];
   wire        rx_receipt_ack  = partner_next_page[`BIT_ACK];
   wire        rx_message_page = partner_next_page[`BIT_MESSAGE];
   wire        rx_comply       = partner_next_page[`BIT_COMPLY];
   wire        rx_toggle       = partner_next_page[`BIT_TOGGLE];
   wire [10:0] rx_code         = partner_next_page[`CODE_MSB:0];

   reserved_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
      tx_page_o[`BIT_ACK] == 1'b0 && !port_configuration[15])
      else $error("Reserved bit set");

   npt_reset_a: assert property (@(posedge clock_i)
      reset_i |=> next_page_transmit == `NPT_RESET)
      else $error("Transmit register reset value wrong");

   npt_fields_reset_a: assert property (@(posedge clock_i)
      reset_i |=> !tx_more_pages && tx_message_page && !tx_comply && !tx_toggle
                  && tx_code == 11'h001)
      else $error("Transmit fields reset wrong");

   npt_write_a: assert property (@(posedge clock_i) disable iff (reset_i)
      wr_npt |=> tx_page_o == ($past(mgmt_i.wdata) & `NPT_WRITE_MASK))
      else $error("Transmit page write lost");

   more_pages_wr_a: assert property (@(posedge clock_i) disable iff (reset_i)
      wr_npt |=> tx_more_pages == $past(mgmt_i.wdata[`BIT_MORE_PAGES]))
      else $error("More pages field not written");

   message_wr_a: assert property (@(posedge clock_i) disable iff (reset_i)
      wr_npt |=> tx_message_page == $past(mgmt_i.wdata[`BIT_MESSAGE]))
      else $error("Message page field not written");

   comply_wr_a: assert property (@(posedge clock_i) disable iff (reset_i)
      wr_npt |=> tx_comply == $past(mgmt_i.wdata[`BIT_COMPLY]))
      else $error("Comply field not written");

   toggle_wr_a: assert property (@(posedge clock_i) disable iff (reset_i)
      wr_npt |=> tx_toggle == $past(mgmt_i.wdata[`BIT_TOGGLE]))
      else $error("Toggle field not written");

   code_wr_a: assert property (@(posedge clock_i) disable iff (reset_i)
      wr_npt |=> tx_code == $past(mgmt_i.wdata[`CODE_MSB:0]))
      else $error("Code field not written");

   npt_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !wr_npt |=> $stable(tx_page_o))
      else $error("Outgoing page changed without write");

   partner_load_a: assert property (@(posedge clock_i) disable iff (reset_i)
      new_page |=> partner_next_page == $past(rx_page_i.word) && page_received)
      else $error("Received page not loaded");

   partner_more_a: assert property (@(posedge clock_i) disable iff (reset_i)
      new_page |=> rx_more_pages == $past(rx_page_i.word[`BIT_MORE_PAGES]))
      else $error("Partner more pages wrong");

   partner_ack_a: assert property (@(posedge clock_i) disable iff (reset_i)
      new_page |=> rx_receipt_ack == $past(rx_page_i.word[`BIT_ACK]))
      else $error("Partner receipt ack wrong");

   partner_message_a: assert property (@(posedge clock_i) disable iff (reset_i)
      new_page |=> rx_message_page == $past(rx_page_i.word[`BIT_MESSAGE]))
      else $error("Partner message page wrong");

   partner_comply_a: assert property (@(posedge clock_i) disable iff (reset_i)
      new_page |=> rx_comply == $past(rx_page_i.word[`BIT_COMPLY]))
      else $error("Partner comply ack wrong");

   partner_code_a: assert property (@(posedge clock_i) disable iff (reset_i)
      new_page |=> rx_toggle == $past(rx_page_i.word[`BIT_TOGGLE])
                   && rx_code == $past(rx_page_i.word[`CODE_MSB:0]))
      else $error("Partner code field wrong");

   partner_reset_a: assert property (@(posedge clock_i)
      reset_i |=> partner_next_page == `PNP_RESET)
      else $error("Partner register reset value wrong");

   partner_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !new_page |=> $stable(partner_next_page))
      else $error("Partner register changed without page");

   flag_rise_a: assert property (@(posedge clock_i) disable iff (reset_i)
      $rose(page_received) |-> $past(new_page))
      else $error("Page flag set without page");

   read_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
      rd_pgrx && !new_page |=> !page_received)
      else $error("Page flag not cleared by read");

   flag_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
      page_received && !rd_pgrx && !alt_clear |=> page_received)
      else $error("Page flag lost before read");

   alt_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
      enable_i && alt_clear && !new_page |=> !page_received)
      else $error("Alternate clear ignored");

   alt_write_a: assert property (@(posedge clock_i) disable iff (reset_i)
      wr_pcfg |=> alt_np_enable_o == $past(mgmt_i.wdata[`BIT_ALT_NP]))
      else $error("Alternate enable not written");

   tx_disable_a: assert property (@(posedge clock_i) disable iff (reset_i)
      wr_pcfg |=> tx_disable_o == $past(mgmt_i.wdata[`BIT_TX_DISABLE])
                  && link_pass_force_o == $past(mgmt_i.wdata[`BIT_LINK_FORCE]))
      else $error("Config control bits not written");

   pcfg_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !wr_pcfg && !strap_pending |=> $stable(port_configuration))
      else $error("Config changed without write");

   strap_load_a: assert property (@(posedge clock_i) disable iff (reset_i)
      strap_pending && enable_i && !wr_pcfg |=> fiber_select_o == $past(fiber_sync))
      else $error("Fiber strap not loaded");

   read_pulse_a: assert property (@(posedge clock_i) disable iff (reset_i)
      enable_i && mgmt_i.read |=> read_valid_o)
      else $error("Read not answered");

   read_idle_a: assert property (@(posedge clock_i) disable iff (reset_i)
      enable_i && !mgmt_i.read |=> !read_valid_o)
      else $error("Read valid without read");

   npt_read_a: assert property (@(posedge clock_i) disable iff (reset_i)
      enable_i && mgmt_i.read && hit_npt |=> read_data_o == $past(tx_page_o)
                                             && !read_data_o[`BIT_ACK])
      else $error("Transmit readback wrong");

   pcfg_read_a: assert property (@(posedge clock_i) disable iff (reset_i)
      enable_i && mgmt_i.read && hit_pcfg |=> !read_data_o[15]
         && read_data_o[14:0] == $past(port_configuration[14:0]))
      else $error("Config readback wrong");

   pnp_read_a: assert property (@(posedge clock_i) disable iff (reset_i)
      enable_i && mgmt_i.read && hit_pnp |=> read_data_o == $past(partner_next_page))
      else $error("Partner readback wrong");

   pgrx_read_a: assert property (@(posedge clock_i) disable iff (reset_i)
      enable_i && mgmt_i.read && hit_pgrx |=>
         read_data_o == {14'h0000, $past(page_received), 1'b0})
      else $error("Page flag readback wrong");

   unmapped_read_a: assert property (@(posedge clock_i) disable iff (reset_i)
      enable_i && mgmt_i.read && !(hit_npt || hit_pnp || hit_pcfg || hit_pgrx)
      |=> read_data_o == 16'h0000)
      else $error("Unmapped read not zero");

   freeze_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !enable_i |=> $stable(partner_next_page) && $stable(port_configuration)
                    && $stable(page_received) && $stable(next_page_transmit))
      else $error("State changed while frozen");

endmodule

// File: verilog/np_regs_map.svh
// Register offsets, field positions, reset values for the next page register set.
// Included by the design; definitions only.
`ifndef NP_REGS_MAP_SVH
`define NP_REGS_MAP_SVH
`define NPT_OFFSET        5'h07
`define PNP_OFFSET        5'h08
`define PCFG_OFFSET       5'h10
`define PGRX_OFFSET       5'h06
`define NPT_RESET         16'h2001
`define PNP_RESET         16'h0000
`define PCFG_RESET        16'h0000
`define NPT_WRITE_MASK    16'hBFFF
`define PCFG_WRITE_MASK   16'h7FFF
`define BIT_MORE_PAGES    15
`define BIT_ACK           14
`define BIT_MESSAGE       13
`define BIT_COMPLY        12
`define BIT_TOGGLE        11
`define BIT_LINK_FORCE    14
`define BIT_TX_DISABLE    13
`define BIT_ALT_NP        1
`define BIT_FIBER         0
`define BIT_PAGE_RX       1
`define CODE_MSB          10
`endif

// File: verilog/np_regs_pkg.sv
// Types shared by the next page register set.
// Assumes the constants header sits beside it.
package np_regs_pkg;
   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } page_type;
   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } mgmt_req_type;
endpackage

// File: sim/page_source.sv
// Stand-in for the negotiation engine that hands received next pages to the registers.
// Assumes the registers sample the page strobe on the rising edge of clock_i.
`timescale 1ns/10ps
module page_source
   import np_regs_pkg::*;
(
   input  wire logic clock_i,
   output page_type  rx_page_o
);
   initial rx_page_o = '{valid: 1'b0, word: 16'h0000};
   // Word lines are not held after the strobe, so show the inverse
   task automatic send(input logic [15:0] word);
      @(posedge clock_i) #1;
      rx_page_o = '{valid: 1'b1, word: word};
      @(posedge clock_i) #1;
      rx_page_o = '{valid: 1'b0, word: ~word};
   endtask
endmodule

// File: sim/autoneg_next_page_regs_test.sv
// Directed bench for the next page register set.
// Assumes the package, the design and the page source model are compiled first.
`timescale 1ns/10ps
module autoneg_next_page_regs_test
   import np_regs_pkg::*;
;
   logic         clock_i    = 1'b0;
   logic         reset_i    = 1'b1;
   logic         active     = 1'b0;
   logic         enable     = 1'b1;
   logic         fiber_pin  = 1'b0;
   mgmt_req_type mgmt       = '0;
   page_type     rx_page;
   logic [15:0]  read_data;
   logic [15:0]  tx_page;
   logic         read_valid, link_force, tx_off, alt_np, fiber, page_flag;
   int           num_errors = 0;
   int           checked    = 0;

   autoneg_next_page_regs autoneg_next_page_regs_inst (
      .clock_i(clock_i), .reset_i(reset_i), .enable_i(enable), .mgmt_i(mgmt),
      .read_data_o(read_data), .read_valid_o(read_valid), .rx_page_i(rx_page),
      .page_rx_active_i(active), .fiber_pin_i(fiber_pin), .tx_page_o(tx_page),
      .link_pass_force_o(link_force), .tx_disable_o(tx_off),
      .alt_np_enable_o(alt_np), .fiber_select_o(fiber), .page_received_o(page_flag));
   page_source page_source_inst (.clock_i(clock_i), .rx_page_o(rx_page));

   initial forever #25 clock_i = ~clock_i;

   task automatic complete_run;
      if (num_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [4:0] addr, input logic [15:0] exp);
      @(posedge clock_i) #1;
      mgmt = '{read: 1'b1, write: 1'b0, addr: addr, wdata: 16'h0000};
      @(posedge clock_i) #1;
      mgmt = '0;
      check({15'h0000, read_valid}, 16'h0001);
      check(read_data, exp);
   endtask

   // Waits one extra cycle so the written value has reached the outputs
   task automatic wr(input logic [4:0] addr, input logic [15:0] data);
      @(posedge clock_i) #1;
      mgmt = '{read: 1'b0, write: 1'b1, addr: addr, wdata: data};
      @(posedge clock_i) #1;
      mgmt = '0;
      @(posedge clock_i) #1;
   endtask

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   initial begin
      wait_cycles(5000);
      num_errors++;
      complete_run();
   end

   initial begin
      wait_cycles(12);
      reset_i = 1'b0;
      rd(5'h07, 16'h2001);
      check(tx_page, 16'h2001);
      rd(5'h08, 16'h0000);
      rd(5'h10, 16'h0000);
      rd(5'h06, 16'h0000);
      wr(5'h07, 16'hFFFF);
      rd(5'h07, 16'hBFFF);
      check(tx_page, 16'hBFFF);
      wr(5'h07, 16'h0000);
      check(tx_page, 16'h0000);
      wr(5'h10, 16'hE000);
      rd(5'h10, 16'h6000);
      check({13'h0000, link_force, tx_off, fiber}, 16'h0006);
      page_source_inst.send(16'hA5C3);
      check({15'h0000, page_flag}, 16'h0001);
      wr(5'h08, 16'h0000);
      rd(5'h08, 16'hA5C3);
      rd(5'h06, 16'h0002);
      check({15'h0000, page_flag}, 16'h0000);
      rd(5'h06, 16'h0000);
      rd(5'h1F, 16'h0000);
      page_source_inst.send(16'h5A3C);
      rd(5'h08, 16'h5A3C);
      wr(5'h10, 16'h0002);
      check({15'h0000, alt_np}, 16'h0001);
      active = 1'b1;
      page_source_inst.send(16'h1234);
      wait_cycles(2);
      check({15'h0000, page_flag}, 16'h0001);
      active = 1'b0;
      wait_cycles(2);
      check({15'h0000, page_flag}, 16'h0000);
      wr(5'h10, 16'h2002);
      active = 1'b1;
      page_source_inst.send(16'h4321);
      wait_cycles(2);
      check({15'h0000, page_flag}, 16'h0000);
      active = 1'b0;
      wr(5'h10, 16'h0000);
      // Page and flag read on one edge: the set must win
      fork
         rd(5'h06, 16'h0000);
         page_source_inst.send(16'h0F0F);
      join
      check({15'h0000, page_flag}, 16'h0001);
      rd(5'h06, 16'h0002);
      rd(5'h08, 16'h0F0F);
      // Second reset with the strap pin high reloads bit 0
      fiber_pin = 1'b1;
      reset_i   = 1'b1;
      wait_cycles(3);
      reset_i   = 1'b0;
      rd(5'h10, 16'h0001);
      rd(5'h07, 16'h2001);
      rd(5'h08, 16'h0000);
      check({15'h0000, page_flag}, 16'h0000);
      // Clock enable low drops a write and a page
      enable = 1'b0;
      wr(5'h07, 16'h1234);
      page_source_inst.send(16'hFFFF);
      enable = 1'b1;
      check(tx_page, 16'h2001);
      check({15'h0000, page_flag}, 16'h0000);
      rd(5'h08, 16'h0000);
      complete_run();
   end
endmodule
